// *** hdl/ttl_top.sv ***
// Logic of a keyboard send-receive printing terminal: keyboard encoder,
// serializer, line counter, printer feed, ribbon, motor and modem leads.
// Assumes all pins are at logic level and asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ttl_top #(
   parameter int unsigned BIT_CYCLES = ttl_pkg::TTL_BIT_CYCLES,
   parameter int unsigned STOP_BITS  = ttl_pkg::TTL_STOP_BITS,
   parameter int unsigned LINE_LIMIT = ttl_pkg::TTL_LINE_LIMIT
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Keyboard side
   input  wire logic [6:0]        key_contacts_i,
   input  wire logic              shift_key_i,
   input  wire logic              control_modifier_key_i,
   input  wire logic              mods_sample_i,
   input  wire logic              take_char_i,
   // Panel and typing unit
   input  wire logic              local_mode_i,
   input  wire logic              force_black_switch_i,
   input  wire logic              stunt_red_i,
   input  wire logic              motor_off_switch_i,
   input  wire logic              maintenance_on_i,
   // Interface leads, interface polarity
   input  wire logic              received_data_i,
   input  wire logic              motor_ctl_ground_i,
   input  wire logic              ribbon_red_ground_i,
   output logic                   send_data_o,
   output ttl_pkg::ttl_modem_t    modem_o,
   // Outputs to the set
   output logic                   printer_magnet_o,
   output logic                   ribbon_red_o,
   output logic                   motor_relay_o,
   output logic                   line_full_lamp_o,
   output logic [ttl_pkg::TTL_CNT_W-1:0] line_count_o,
   output logic [7:0]             last_char_o,
   output logic                   tx_busy_o
);
   import ttl_pkg::*;

   initial begin
      if (LINE_LIMIT < 1 || LINE_LIMIT >= (1 << TTL_CNT_W)) begin
         $error("ttl_top: LINE_LIMIT does not fit the line counter");
      end
      if (BIT_CYCLES < 2 || STOP_BITS < 1) begin
         $error("ttl_top: bit period or stop count too small");
      end
   end

   localparam logic [TTL_CNT_W-1:0] LIMIT = TTL_CNT_W'(LINE_LIMIT);
   // Count saturates rather than wrapping, so a runaway line keeps the lamp lit
   localparam logic [TTL_CNT_W-1:0] CNT_MAX = '1;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Modifier keys act on the raw contact pattern
   function automatic logic [6:0] encode_key(input logic [6:0] raw,
                                             input ttl_mods_t mods);
      logic [6:0] c;
      c = raw;
      if (mods.shift) begin
         if (c[TTL_ALPHA_BIT]) begin
            c[TTL_CASE_BIT] = 1'b0;
         end else if (c[TTL_CASE_BIT]) begin
            c[TTL_SYM_BIT] = ~c[TTL_SYM_BIT];
         end
      end
      if (mods.ctrl) begin
         c[TTL_ALPHA_BIT] = 1'b0;
         c[TTL_CASE_BIT]  = 1'b0;
      end
      return c;
   endfunction : encode_key

   function automatic logic even_parity(input logic [6:0] c);
      return ^c;
   endfunction : even_parity

   // Printable codes advance the carriage; space counts as one
   function automatic logic is_printable(input logic [6:0] c);
      return (c >= TTL_CHR_SPACE) && (c != TTL_CHR_DEL);
   endfunction : is_printable

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   localparam int unsigned SYNC_W = 7 + 7;

   // Motor and red leads idle open (high); resetting them low would run the
   // motor and shift to red for two cycles after every reset
   localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(2'h3);

   logic [SYNC_W-1:0] sync1_q, sync2_q;
   logic [SYNC_W-1:0] pins;

   // The contact word crosses bit by bit with no handshake: it is settled
   // well before the take contact closes, and is read only on that edge
   assign pins = {key_contacts_i, shift_key_i, control_modifier_key_i,
                  mods_sample_i, take_char_i, received_data_i,
                  motor_ctl_ground_i, ribbon_red_ground_i};

   // Control-panel levels ride on a separate two-stage chain below
   logic [4:0] pan1_q, pan2_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_q <= SYNC_IDLE;
         sync2_q <= SYNC_IDLE;
         pan1_q  <= '0;
         pan2_q  <= '0;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
         pan1_q  <= {local_mode_i, force_black_switch_i, stunt_red_i,
                     motor_off_switch_i, maintenance_on_i};
         pan2_q  <= pan1_q;
      end
   end

   // Synchronised copies; nothing reads the first stage
   logic [6:0] contacts_s;
   logic       shift_s;
   logic       ctrl_s;
   logic       sample_s;
   logic       take_s;
   logic       rxd_s;
   logic       motor_gnd_s;
   logic       red_gnd_s;
   logic       local_s;
   logic       black_s;
   logic       stunt_red_s;
   logic       motor_off_s;
   logic       maint_s;

   assign {contacts_s, shift_s, ctrl_s, sample_s, take_s, rxd_s,
           motor_gnd_s, red_gnd_s} = sync2_q;
   assign {local_s, black_s, stunt_red_s, motor_off_s, maint_s} = pan2_q;

   ////////////////////////////////////////////////////////////////////////
   // Keyboard encoder

   ttl_mods_t  mods_q, mods_d;
   logic       sample_prev_q;
   logic       take_prev_q;
   logic [7:0] char_q, char_d;
   logic       start_q, start_d;
   logic       sample_rise;
   logic       take_rise;
   logic       ser_busy;
   logic [6:0] code;

   // Edge detectors reset to the idle low level of their pins: no false take
   assign sample_rise = sample_s & ~sample_prev_q;
   assign take_rise   = take_s & ~take_prev_q;

   always_comb begin
      mods_d  = mods_q;
      char_d  = char_q;
      start_d = 1'b0;
      // Latched modifiers, not the live keys, shape the code
      code    = encode_key(contacts_s, mods_q);
      // Modifiers are frozen before the character is read, so a modifier
      // pressed late cannot flip parity mid-character
      if (sample_rise) begin
         mods_d.shift = shift_s;
         mods_d.ctrl  = ctrl_s;
      end
      // A take while the serializer is busy is dropped; the keyboard
      // mechanism paces characters well below the line rate
      if (take_rise && !ser_busy) begin
         char_d  = {even_parity(code), code};
         start_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mods_q        <= '0;
         sample_prev_q <= 1'b0;
         take_prev_q   <= 1'b0;
         char_q        <= '0;
         start_q       <= 1'b0;
      end else begin
         mods_q        <= mods_d;
         sample_prev_q <= sample_s;
         take_prev_q   <= take_s;
         char_q        <= char_d;
         start_q       <= start_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serializer and send line

   logic tx_line;

   // The serializer owns the crystal bit timer; a bit lasts BIT_CYCLES clocks
   ttl_serializer #(
      .BIT_CYCLES (BIT_CYCLES),
      .STOP_BITS  (STOP_BITS)
   ) u_ser (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (start_q),
      .data_i  (char_q),
      .busy_o  (ser_busy),
      .line_o  (tx_line)
   );

   logic send_q, send_d;

   always_comb begin
      // Interface data is inverted: mark low, space high
      send_d = ~tx_line;
      if (local_s) begin
         send_d = ~TTL_LOGIC_MARK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive path to the printer

   logic magnet_q, magnet_d;

   always_comb begin
      // On line the receive path never looks at the send path
      magnet_d = ~rxd_s;
      if (local_s) begin
         magnet_d = tx_line;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         // Both lines rest at mark: reset sends no break and prints nothing
         send_q   <= ~TTL_LOGIC_MARK;
         magnet_q <= TTL_LOGIC_MARK;
      end else begin
         send_q   <= send_d;
         magnet_q <= magnet_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line character counter and lamp

   logic [TTL_CNT_W-1:0] cnt_q, cnt_d;
   logic                 lamp_q, lamp_d;
   logic [6:0]           cc;

   always_comb begin
      cnt_d  = cnt_q;
      lamp_d = lamp_q;
      cc     = char_q[6:0];
      if (start_q) begin
         if (cc == TTL_CHR_CR || cc == TTL_CHR_LF) begin
            cnt_d = '0;
         end else if (cc == TTL_CHR_BS) begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end
         end else if (is_printable(cc) && cnt_q != CNT_MAX) begin
            cnt_d = cnt_q + 1'b1;
         end
      end
      // Decoded from the next count so lamp and count move together
      lamp_d = (cnt_d >= LIMIT);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q  <= '0;
         lamp_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         lamp_q <= lamp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ribbon colour

   logic red_q, red_d;

   always_comb begin
      // Interface red always wins; the panel only blocks stunt-box red
      red_d = ~red_gnd_s | (stunt_red_s & ~black_s);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         red_q <= 1'b0;
      end else begin
         red_q <= red_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Motor relay and modem leads

   logic motor_q, motor_d;
   logic motor_cmd;

   // A grounded lead reads low at logic level and means on
   assign motor_cmd = ~motor_gnd_s;

   always_comb begin
      // Local mode parks the motor lead; only maintenance runs the motor then
      motor_d = (motor_cmd & ~motor_off_s & ~local_s) | maint_s;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         motor_q <= 1'b0;
      end else begin
         motor_q <= motor_d;
      end
   end

   // Fixed leads: request and ready high, ring and clear low
   assign modem_o.rts = TTL_EIA_ON;
   assign modem_o.dtr = TTL_EIA_ON;
   assign modem_o.ri  = TTL_EIA_OFF;
   assign modem_o.cts = TTL_EIA_OFF;

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign send_data_o      = send_q;
   assign printer_magnet_o = magnet_q;
   assign ribbon_red_o     = red_q;
   assign motor_relay_o    = motor_q;
   assign line_full_lamp_o = lamp_q;
   assign line_count_o     = cnt_q;
   assign last_char_o      = char_q;
   assign tx_busy_o        = ser_busy;

endmodule : ttl_top
`default_nettype wire

// *** hdl/ttl_pkg.sv ***
// Notes on behaviour
// - Keyboard contacts become ASCII, even parity bit eight
// - Parity settled from sampled shift/control state
// - Take-character pulse starts serializing the character
// - Crystal bit timer paces every serialized bit
// - Serializer output drives the send data line
// - Received data line drives printer selector magnets
// - Printable keyboard characters increment line counter
// - Carriage return or new line clears counter
// - Keyboard backspace decrements line counter
// - Lamp lights at threshold, default eighty
// - Interface red selects red; panel/decode select black
// - RTS, DTR held high; RI, CTS held low
// - Data lines: spacing high, marking low
// - Control line high means on, low off
// - Internal levels inverted against the interface
// - On-line: send and receive paths independent
// - Grounded motor lead keeps motor running
// - Motor relay follows interface motor-on command
// - Counter reset extinguishes the line lamp
// - Force-black never overrides interface red request
// - Local mode loops send into receive path
//
// Shared constants and carriers of the terminal logic.
// Assumes one 10 MHz clock and interface pins already at logic level.
package ttl_pkg;

   localparam int unsigned TTL_CLK_HZ       = 10_000_000;
   localparam int unsigned TTL_BIT_RATE_BPS = 110;
   localparam int unsigned TTL_BIT_CYCLES   = TTL_CLK_HZ / TTL_BIT_RATE_BPS;
   localparam int unsigned TTL_STOP_BITS    = 2;
   localparam int unsigned TTL_LINE_LIMIT   = 80;
   localparam int unsigned TTL_CNT_W        = 7;

   // Character codes that steer the line counter
   localparam logic [6:0] TTL_CHR_BS    = 7'h08;
   localparam logic [6:0] TTL_CHR_LF    = 7'h0A;
   localparam logic [6:0] TTL_CHR_CR    = 7'h0D;
   localparam logic [6:0] TTL_CHR_SPACE = 7'h20;
   localparam logic [6:0] TTL_CHR_DEL   = 7'h7F;

   // Bit positions used by the shift and control encoding
   localparam int unsigned TTL_CASE_BIT  = 5;
   localparam int unsigned TTL_ALPHA_BIT = 6;
   localparam int unsigned TTL_SYM_BIT   = 4;

   // Interface line levels
   localparam logic TTL_EIA_ON    = 1'b1;
   localparam logic TTL_EIA_OFF   = 1'b0;
   localparam logic TTL_LOGIC_MARK = 1'b1;

   typedef struct packed {
      logic shift;
      logic ctrl;
   } ttl_mods_t;

   typedef struct packed {
      logic rts;
      logic cts;
      logic dtr;
      logic ri;
   } ttl_modem_t;

endpackage : ttl_pkg

// *** hdl/ttl_serializer.sv ***
// Asynchronous character serializer with its own crystal bit timer.
// Assumes start_i is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ttl_serializer #(
   parameter int unsigned BIT_CYCLES = ttl_pkg::TTL_BIT_CYCLES,
   parameter int unsigned STOP_BITS  = ttl_pkg::TTL_STOP_BITS
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic [7:0] data_i,
   output logic            busy_o,
   output logic            line_o
);
   import ttl_pkg::*;

   localparam int unsigned FRAME_W = 1 + 8 + STOP_BITS;
   localparam int unsigned TMR_W   = $clog2(BIT_CYCLES + 1);
   localparam int unsigned IDX_W   = $clog2(FRAME_W + 1);

   initial begin
      if (BIT_CYCLES < 2 || STOP_BITS < 1) begin
         $error("ttl_serializer: bit period or stop count too small");
      end
   end

   logic [FRAME_W-1:0] shift_q, shift_d;
   logic [TMR_W-1:0]   tmr_q, tmr_d;
   logic [IDX_W-1:0]   left_q, left_d;
   logic               line_q, line_d;

   always_comb begin
      shift_d = shift_q;
      tmr_d   = tmr_q;
      left_d  = left_q;
      line_d  = line_q;
      if (left_q == '0) begin
         line_d = TTL_LOGIC_MARK;
         if (start_i) begin
            // Stops, data LSB first, start bit low
            shift_d = {{STOP_BITS{TTL_LOGIC_MARK}}, data_i, ~TTL_LOGIC_MARK};
            left_d  = IDX_W'(FRAME_W);
            tmr_d   = TMR_W'(BIT_CYCLES - 1);
            line_d  = ~TTL_LOGIC_MARK;
         end
      end else if (tmr_q == '0) begin
         left_d = left_q - 1'b1;
         tmr_d  = TMR_W'(BIT_CYCLES - 1);
         shift_d = {TTL_LOGIC_MARK, shift_q[FRAME_W-1:1]};
         line_d  = (left_q == IDX_W'(1)) ? TTL_LOGIC_MARK : shift_q[1];
      end else begin
         tmr_d = tmr_q - 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_q <= '1;
         tmr_q   <= '0;
         left_q  <= '0;
         line_q  <= TTL_LOGIC_MARK;
      end else begin
         shift_q <= shift_d;
         tmr_q   <= tmr_d;
         left_q  <= left_d;
         line_q  <= line_d;
      end
   end

   assign busy_o = (left_q != '0);
   assign line_o = line_q;

endmodule : ttl_serializer
`default_nettype wire

// *** tb/ttl_top_asserts.sv ***
// Port-level checks on the terminal logic.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ttl_top_asserts #(
   parameter int unsigned BIT_CYCLES = ttl_pkg::TTL_BIT_CYCLES,
   parameter int unsigned STOP_BITS  = ttl_pkg::TTL_STOP_BITS,
   parameter int unsigned LINE_LIMIT = ttl_pkg::TTL_LINE_LIMIT
) (
   input wire logic                          clk_i,
   input wire logic                          rst_i,
   input wire logic                          local_mode_i,
   input wire logic                          force_black_switch_i,
   input wire logic                          stunt_red_i,
   input wire logic                          motor_off_switch_i,
   input wire logic                          maintenance_on_i,
   input wire logic                          received_data_i,
   input wire logic                          motor_ctl_ground_i,
   input wire logic                          ribbon_red_ground_i,
   input wire logic                          send_data_o,
   input wire ttl_pkg::ttl_modem_t           modem_o,
   input wire logic                          printer_magnet_o,
   input wire logic                          ribbon_red_o,
   input wire logic                          motor_relay_o,
   input wire logic                          line_full_lamp_o,
   input wire logic [ttl_pkg::TTL_CNT_W-1:0] line_count_o,
   input wire logic [7:0]                    last_char_o,
   input wire logic                          tx_busy_o
);
   import ttl_pkg::*;
   localparam int unsigned FRAME = (9 + STOP_BITS) * BIT_CYCLES;
   int unsigned busy_q, busy_d;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_comb begin
      busy_d = tx_busy_o ? busy_q + 1 : 0;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         busy_q <= 0;
      else
         busy_q <= busy_d;
   end
   ////////////////////
   AST_MODEM: assert property (modem_o == 4'hA)
      else $error("modem leads moved");
   AST_PARITY: assert property (^last_char_o == 1'h0)
      else $error("odd parity");
   AST_LAMP: assert property
      (line_full_lamp_o == (line_count_o >= LINE_LIMIT))
      else $error("lamp wrong");
   AST_COUNT_STEP: assert property
      ($changed(line_count_o) |-> line_count_o == 0 ||
       line_count_o == $past(line_count_o) + 1 || line_count_o == $past(line_count_o) - 1)
      else $error("count jumped");
   AST_CR_CLEARS: assert property
      ($changed(last_char_o) && (last_char_o[6:0] == TTL_CHR_CR ||
       last_char_o[6:0] == TTL_CHR_LF) |-> ##[0:2] line_count_o == 0)
      else $error("count not cleared");
   AST_LOCAL_QUIET: assert property (local_mode_i [*5] |-> !send_data_o)
      else $error("send line active in local");
   AST_MAGNET: assert property
      ((!local_mode_i && $stable(received_data_i)) [*6] |-> printer_magnet_o == !received_data_i)
      else $error("magnet wrong");
   AST_MOTOR: assert property
      ($stable({motor_ctl_ground_i, motor_off_switch_i, local_mode_i, maintenance_on_i}) [*6]
       |-> motor_relay_o == ((!motor_ctl_ground_i && !motor_off_switch_i && !local_mode_i)
       || maintenance_on_i))
      else $error("relay wrong");
   AST_RIBBON: assert property
      ($stable({ribbon_red_ground_i, stunt_red_i, force_black_switch_i}) [*6]
       |-> ribbon_red_o == (!ribbon_red_ground_i || (stunt_red_i && !force_black_switch_i)))
      else $error("ribbon wrong");
   // Allows one cycle of start skew below the frame and two above
   AST_FRAME_LEN: assert property
      ($fell(tx_busy_o) |-> busy_q >= FRAME - 1 && busy_q <= FRAME + 2)
      else $error("frame length wrong");
   cover property ($rose(line_full_lamp_o));
   cover property ($fell(tx_busy_o) && local_mode_i);
   cover property (motor_relay_o && maintenance_on_i);
endmodule : ttl_top_asserts
bind ttl_top ttl_top_asserts #(.BIT_CYCLES(BIT_CYCLES), .STOP_BITS(STOP_BITS),
   .LINE_LIMIT(LINE_LIMIT)) u_chk (.clk_i, .rst_i, .local_mode_i, .force_black_switch_i,
   .stunt_red_i, .motor_off_switch_i, .maintenance_on_i, .received_data_i,
   .motor_ctl_ground_i, .ribbon_red_ground_i, .send_data_o, .modem_o, .printer_magnet_o,
   .ribbon_red_o, .motor_relay_o, .line_full_lamp_o, .line_count_o, .last_char_o, .tx_busy_o);
`default_nettype wire

// *** tb/ttl_conv_model.sv ***
// Far-side code converter: decodes the send line, drives the receive line.
// Assumes interface polarity on its pins: spacing high, marking low.
`timescale 1ns/1ps
`default_nettype none
module ttl_conv_model #(
   parameter int unsigned BIT_CYCLES = 8
) (
   input  wire logic clk_i,
   input  wire logic line_i,
   input  wire logic motor_on_i,
   input  wire logic red_i,
   output logic      rx_line_o,
   output logic      motor_gnd_o,
   output logic      red_gnd_o
);
   logic [7:0] rx_q = 8'h00;
   int         n_rx = 0;
   int         n_bad = 0;
   // Grounded lead means on, open means off
   assign motor_gnd_o = ~motor_on_i;
   assign red_gnd_o = ~red_i;
   initial rx_line_o = 1'h0;
   always begin : decode
      logic [7:0] b;
      // Sample mid-cycle, clear of the edge that moves the line
      @(negedge clk_i);
      if (line_i === 1'h1) begin
         repeat (BIT_CYCLES / 2) @(negedge clk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(negedge clk_i);
            b[i] = ~line_i;
         end
         repeat (BIT_CYCLES) @(negedge clk_i);
         if (line_i !== 1'h0)
            n_bad++;
         rx_q = b;
         n_rx++;
      end
   end
   task automatic send_byte(input logic [7:0] b);
      logic [10:0] f;
      f = {2'h3, b, 1'h0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk_i);
         #1 rx_line_o = ~f[i];
         repeat (BIT_CYCLES - 1) @(posedge clk_i);
      end
   endtask : send_byte
endmodule : ttl_conv_model
`default_nettype wire

// *** tb/tb.sv ***
// Bench for the terminal logic, with the converter model on the far side.
// Assumes short bit period and line limit; local mode is watched via the magnet.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ttl_pkg::*;
   localparam int unsigned BC = 8;
   localparam int unsigned LIM = 6;
   localparam logic [8:0] CORNER [16] = '{9'h008, 9'h161, 9'h131, 9'h0E7, 9'h078, 9'h078,
      9'h078, 9'h078, 9'h078, 9'h078, 9'h078, 9'h008, 9'h008, 9'h00D, 9'h078, 9'h00A};
   logic clk_i = 1'h0, rst_i = 1'h1, take_char_i = 1'h0, local_mode_i = 1'h0;
   logic [6:0] key_contacts_i = 7'h00;
   logic shift_key_i = 1'h0, control_modifier_key_i = 1'h0, mods_sample_i = 1'h0;
   logic force_black_switch_i = 1'h0, stunt_red_i = 1'h0, motor_off_switch_i = 1'h0;
   logic maintenance_on_i = 1'h0, want_motor = 1'h0, want_red = 1'h0;
   logic received_data_i, motor_ctl_ground_i, ribbon_red_ground_i, send_data_o, tx_busy_o;
   logic printer_magnet_o, ribbon_red_o, motor_relay_o, line_full_lamp_o;
   ttl_modem_t modem_o;
   logic [TTL_CNT_W-1:0] line_count_o;
   logic [7:0] last_char_o;
   logic [31:0] seed = 32'h0000_0051;
   int n_errors = 0, checks_done = 0, cnt = 0;
   ttl_top #(.BIT_CYCLES(BC), .STOP_BITS(2), .LINE_LIMIT(LIM)) dut (.clk_i, .rst_i,
      .key_contacts_i, .shift_key_i, .control_modifier_key_i, .mods_sample_i, .take_char_i,
      .local_mode_i, .force_black_switch_i, .stunt_red_i, .motor_off_switch_i,
      .maintenance_on_i, .received_data_i, .motor_ctl_ground_i, .ribbon_red_ground_i,
      .send_data_o, .modem_o, .printer_magnet_o, .ribbon_red_o, .motor_relay_o,
      .line_full_lamp_o, .line_count_o, .last_char_o, .tx_busy_o);
   ttl_conv_model #(.BIT_CYCLES(BC)) conv (.clk_i,
      .line_i(local_mode_i ? ~printer_magnet_o : send_data_o), .motor_on_i(want_motor),
      .red_i(want_red), .rx_line_o(received_data_i), .motor_gnd_o(motor_ctl_ground_i),
      .red_gnd_o(ribbon_red_ground_i));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   ////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [7:0] enc(input logic [6:0] c, input logic s, input logic k);
      if (s && c[6])
         c[5] = 1'h0;
      else if (s && c[5])
         c[4] = ~c[4];
      if (k)
         c[6:5] = 2'h0;
      return {^c, c};
   endfunction : enc
   function automatic int nxt(input int n, input logic [6:0] c);
      if (c == TTL_CHR_CR || c == TTL_CHR_LF)
         return 0;
      if (c == TTL_CHR_BS)
         return (n > 0) ? n - 1 : 0;
      if (c >= TTL_CHR_SPACE && c < TTL_CHR_DEL)
         return (n < 127) ? n + 1 : n;
      return n;
   endfunction : nxt
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic key(input logic [8:0] v, input bit dbl);
      logic [7:0] e;
      int r;
      e = enc(v[6:0], v[8], v[7]);
      r = conv.n_rx;
      key_contacts_i = v[6:0];
      {shift_key_i, control_modifier_key_i} = v[8:7];
      mods_sample_i = 1'h1;
      cyc(4);
      mods_sample_i = 1'h0;
      // Modifiers flip after the sample so a stale latch would show
      {shift_key_i, control_modifier_key_i} = ~v[8:7];
      cyc(2);
      take_char_i = 1'h1;
      cyc(4);
      take_char_i = 1'h0;
      if (dbl) begin
         cyc(BC * 3);
         take_char_i = 1'h1;
         cyc(4);
         take_char_i = 1'h0;
      end
      for (int i = 0; i < 200 && conv.n_rx == r; i++) cyc(1);
      for (int i = 0; i < 60 && tx_busy_o !== 1'h0; i++) cyc(1);
      cnt = nxt(cnt, e[6:0]);
      chk(conv.rx_q, e);
      chk(last_char_o, e);
      chk(8'(line_count_o), 8'(cnt));
      chk(8'(line_full_lamp_o), 8'(cnt >= LIM));
      if (dbl) begin
         cyc(BC * 14);
         chk(8'(conv.n_rx - r), 8'h01);
      end
   endtask : key
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (30000) @(posedge clk_i);
      n_errors++;
      conclude();
   end
   initial begin
      cyc(2);
      chk({3'h0, send_data_o, printer_magnet_o, motor_relay_o, ribbon_red_o,
         line_full_lamp_o}, 8'h08);
      chk(8'(modem_o), 8'h0A);
      rst_i = 1'h0;
      cyc(1);
      // Open motor and red leads must not pulse relay or ribbon after reset
      chk({6'h00, motor_relay_o, ribbon_red_o}, 8'h00);
      cyc(3);
      foreach (CORNER[i]) key(CORNER[i], i == 1);
      $display("corner keys done");
      for (int i = 0; i < 12; i++) begin
         fork
            conv.send_byte(i == 0 ? 8'h08 : 8'(rnd()));
            key(9'(rnd()), 1'h0);
         join
      end
      $display("duplex random done");
      local_mode_i = 1'h1;
      cyc(6);
      key(9'(rnd()), 1'h0);
      key(9'(rnd()), 1'h0);
      $display("local loop done");
      for (int i = 0; i < 128; i++) begin
         {maintenance_on_i, motor_off_switch_i, local_mode_i, stunt_red_i,
            force_black_switch_i, want_motor, want_red} = 7'(i);
         cyc(8);
         chk(8'(motor_relay_o), 8'((want_motor & ~motor_off_switch_i & ~local_mode_i)
            | maintenance_on_i));
         chk(8'(ribbon_red_o), 8'(want_red | (stunt_red_i & ~force_black_switch_i)));
      end
      $display("motor and ribbon done");
      chk(8'(conv.n_bad), 8'h00);
      conclude();
   end
endmodule : tb
`default_nettype wire
